// file: design/vsp_pkg.sv
// Shared constants, types and link-word functions for the video serdes pin logic
package vsp_pkg;

	localparam int DATA_W = 12;
	localparam int WORD_W = 15;
	localparam int FIFO_DEPTH = 32;
	localparam int SYNC_W = 27;
	localparam int ADDR_W = 7;
	localparam int STRAP_W = 3;

	// Link word layout
	localparam int POS_VS = 12;
	localparam int POS_HS = 13;
	localparam int POS_INV = 14;
	localparam int RAW_ONES_HALF = 7;

	// Pixel clock limits in MHz per payload
	localparam int MIN_PIX_MHZ = 25;
	localparam int MAX_PIX_MHZ_10 = 100;
	localparam int MAX_PIX_MHZ_12 = 75;

	// Least spacing of sync changes in 10-bit payload, in pixel clocks
	localparam logic [3:0] SYNC_GAP_PIX = 4'ha;

	// Clock rates in kHz and the derived half periods in mclk cycles
	localparam int MCLK_KHZ = 50000;
	localparam int PCLK_OUT_KHZ = 12500;
	localparam int OSC_OUT_KHZ = 6250;
	localparam logic [2:0] PCLK_HALF_CYC = 3'(MCLK_KHZ / (2 * PCLK_OUT_KHZ));
	localparam logic [2:0] OSC_HALF_CYC = 3'(MCLK_KHZ / (2 * OSC_OUT_KHZ));

	// Control bus address base; the value is arbitrary
	localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h40;

	// Values after reset: local-register operation, 10-bit payload, falling edges
	localparam logic [3:0] FORWARD_RESET = 4'h0;
	localparam logic [3:0] LOCAL_RESET = 4'h0;

	typedef struct packed {
		logic pixClkPrev;
		logic payload12;
		logic txEdge;
		logic rxEdge;
		logic sleepSel;
		logic [3:0] forward;
		logic [3:0] serLocal;
		logic [3:0] desLocal;
		logic strapDone;
		logic oscMode;
		logic [ADDR_W-1:0] addr;
		logic [3:0] gapCnt;
		logic hsPrev;
		logic vsPrev;
		logic syncFault;
		logic signed [5:0] disp;
		logic capValid;
		logic [WORD_W-1:0] capWord;
		logic lockOut;
		logic pclk;
		logic [2:0] pclkCnt;
		logic [DATA_W-1:0] pixOut;
		logic hsOut;
		logic vsOut;
		logic oscOut;
		logic [2:0] oscCnt;
		logic oscInPrev;
		logic oscSeen;
		logic [3:0] remoteOut;
		logic [3:0] remoteOe_n;
		logic [3:0] gpioOut;
		logic [3:0] gpioOe_n;
	} vsp_top_s;

	// Gap counter starts saturated, so the first sync change after reset is never a fault
	localparam vsp_top_s TOP_RESET = '{forward: FORWARD_RESET, serLocal: LOCAL_RESET,
		gapCnt: SYNC_GAP_PIX,
		desLocal: LOCAL_RESET, gpioOe_n: 4'h0, default: '0};

	function automatic logic [4:0] onesCount(input logic [13:0] raw);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < 14; i++)
		begin
			n = n + 5'(raw[i]);
		end
		return n;
	endfunction

	// Invert the word when its imbalance would push the running disparity further out
	function automatic logic [WORD_W-1:0] dcEncode(input logic [13:0] raw,
		input logic signed [5:0] disp);
		logic [4:0] ones;
		ones = onesCount(raw);
		if ((ones > 5'(RAW_ONES_HALF) && disp > 6'sd0) ||
			(ones < 5'(RAW_ONES_HALF) && disp < 6'sd0))
		begin
			return {1'b1, ~raw};
		end
		return {1'b0, raw};
	endfunction

	function automatic logic signed [5:0] dispStep(input logic [WORD_W-1:0] word,
		input logic signed [5:0] disp);
		logic signed [6:0] t;
		t = 7'(disp) + $signed({1'b0, onesCount(word[13:0]), 1'b0}) - 7'sd14;
		return t[5:0];
	endfunction

	function automatic logic [13:0] dcDecode(input logic [WORD_W-1:0] word);
		return word[POS_INV] ? ~word[13:0] : word[13:0];
	endfunction

endpackage

// file: design/vsp_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module vsp_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Pins and filtered levels
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] levelOut
);

	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
		logic [W-1:0] stage3;
		logic [W-1:0] level;
	} vsp_sync_s;

	vsp_sync_s q;
	vsp_sync_s d;

	// Stage one feeds stage two only, so nothing reads a metastable value
	always_comb
	begin
		d = q;
		d.stage1 = pinIn;
		d.stage2 = q.stage1;
		d.stage3 = q.stage2;
		for (int i = 0; i < W; i++)
		begin
			if (q.stage2[i] == q.stage3[i])
			begin
				d.level[i] = q.stage3[i];
			end
		end
		if (!reset_n)
		begin
			d = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		q <= d;
	end

	assign levelOut = q.level;

endmodule

// file: design/vsp_fifo.sv
// Pixel word FIFO with valid and ready on both sides
`timescale 1ns/10ps
module vsp_fifo #(
	parameter int WIDTH = vsp_pkg::WORD_W,
	parameter int DEPTH = vsp_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW:0] wrPtr;
		logic [PW:0] rdPtr;
	} vsp_fifo_s;

	vsp_fifo_s q;
	vsp_fifo_s d;
	logic full;
	logic empty;

	assign full = (q.wrPtr[PW] != q.rdPtr[PW]) && (q.wrPtr[PW-1:0] == q.rdPtr[PW-1:0]);
	assign empty = q.wrPtr == q.rdPtr;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = q.mem[q.rdPtr[PW-1:0]];

	always_comb
	begin
		d = q;
		if (inValid && !full)
		begin
			d.mem[q.wrPtr[PW-1:0]] = inData;
			d.wrPtr = q.wrPtr + 1'b1;
		end
		if (outReady && !empty)
		begin
			d.rdPtr = q.rdPtr + 1'b1;
		end
		if (!reset_n)
		begin
			d.wrPtr = '0;
			d.rdPtr = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		q <= d;
	end

	property p_fifo_no_overrun;
		@(posedge mclk) disable iff (!reset_n)
		full && !(outReady && outValid) |=> $stable(q.wrPtr) && !inReady;
	endproperty
	a_fifo_no_overrun: assert property (p_fifo_no_overrun)
		else $error("fifo write pointer moved while full");

endmodule

// file: design/vsp_pin_logic.sv
// Pin-level pixel capture, link select, pixel output and general-purpose pin logic
//
// Summary of operation
// - 10-bit payload carries pixels up to 100 MHz; upper two bits cleared.
// - 12-bit payload carries all twelve bits, limited to 75 MHz pixel clock.
// - Pixel clock from 25 to 100 MHz times the captured pixels.
// - Twelve data bits plus line and frame sync travel together in one word.
// - Inputs sampled on pixel clock edge chosen by the transmit edge select bit.
// - Output pixels launched on output clock edge chosen by receive edge select.
// - A two-way selector forwards exactly one incoming link at a time.
// - Control traffic runs continuously, independent of video blanking.
// - Link words carry DC-balance inversion; timing travels with the data.
// - Power-down low stops the clocks and returns all settings to defaults.
// - Remote outputs 0 and 1 forward deserializer pins or local values.
// - Remote output 2 becomes an oscillator clock output in oscillator mode.
// - Remote pin 3 becomes an oscillator clock input in oscillator mode.
// - Mode strap chooses pixel clock timing or external oscillator timing.
// - Address strap level sets the control bus device address.
// - Deserializer pins 0 and 1 are forwarded inputs or local outputs.
// - In oscillator mode deserializer pins 2 and 3 are local outputs only.
// - Link select low uses input A, high uses input B.
// - Unlocked receiver drives lock low and outputs to the sleep state.
`timescale 1ns/10ps
module vsp_pin_logic (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Power-down pin and straps
	input wire logic powerDown_n,
	input wire logic modeStrap,
	input wire logic [vsp_pkg::STRAP_W-1:0] addressStrap,
	// Serializer pixel input
	input wire logic pixClkIn,
	input wire logic [vsp_pkg::DATA_W-1:0] pixDataIn,
	input wire logic lineSyncIn,
	input wire logic frameSyncIn,
	output logic captureReady,
	// Configuration
	input wire logic cfgLoad,
	input wire logic cfgPayload12,
	input wire logic cfgTxSampleEdgeSel,
	input wire logic cfgRxLaunchEdgeSel,
	input wire logic cfgSleepStateSelect,
	input wire logic [3:0] cfgForward,
	input wire logic [3:0] cfgSerLocal,
	input wire logic [3:0] cfgDesLocal,
	// Status
	output logic [vsp_pkg::ADDR_W-1:0] i2cAddress,
	output logic oscModeOut,
	output logic syncFault,
	output logic oscClockSeen,
	// Second incoming link
	input wire logic [vsp_pkg::WORD_W-1:0] linkBWord,
	input wire logic linkBValid,
	output logic linkBReady,
	// Receiver lock and link select
	input wire logic rxPllLocked,
	input wire logic linkSel,
	output logic lockOut,
	// Deserializer pixel output
	output logic [vsp_pkg::DATA_W-1:0] pixelDataOut,
	output logic lineSyncOut,
	output logic frameSyncOut,
	output logic pixClkOut,
	// Serializer remote output pins
	output logic [3:0] remoteOutput,
	output logic [3:0] remoteOutputOe_n,
	input wire logic oscClockIn,
	// Deserializer general-purpose pins
	input wire logic [3:0] gpioIn,
	output logic [3:0] gpioOut,
	output logic [3:0] gpioOe_n
);

	vsp_pkg::vsp_top_s q;
	vsp_pkg::vsp_top_s d;
	logic [vsp_pkg::SYNC_W-1:0] syncLevel;
	logic sPixClk;
	logic [vsp_pkg::DATA_W-1:0] sData;
	logic sHs;
	logic sVs;
	logic sPd;
	logic sMode;
	logic [vsp_pkg::STRAP_W-1:0] sAddr;
	logic sLocked;
	logic sLinkSel;
	logic [3:0] sGpio;
	logic sOscIn;
	logic fifoReset_n;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [vsp_pkg::WORD_W-1:0] fifoOutWord;
	logic pixEdge;
	logic launch;
	logic selValid;
	logic [vsp_pkg::WORD_W-1:0] selWord;
	logic [13:0] raw;
	logic [13:0] dec;
	logic [3:0] fwd;

	vsp_pin_sync #(
		.W(vsp_pkg::SYNC_W)
	) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pinIn({oscClockIn, gpioIn, linkSel, rxPllLocked, addressStrap, modeStrap,
			powerDown_n, frameSyncIn, lineSyncIn, pixDataIn, pixClkIn}),
		.levelOut(syncLevel)
	);

	assign sPixClk = syncLevel[0];
	assign sData = syncLevel[12:1];
	assign sHs = syncLevel[13];
	assign sVs = syncLevel[14];
	assign sPd = syncLevel[15];
	assign sMode = syncLevel[16];
	assign sAddr = syncLevel[19:17];
	assign sLocked = syncLevel[20];
	assign sLinkSel = syncLevel[21];
	assign sGpio = syncLevel[25:22];
	assign sOscIn = syncLevel[26];

	// Power-down empties the FIFO as well, so stale pixels never leak out afterwards
	assign fifoReset_n = reset_n && sPd;

	vsp_fifo #(
		.WIDTH(vsp_pkg::WORD_W),
		.DEPTH(vsp_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset_n(fifoReset_n),
		.inValid(q.capValid),
		.inData(q.capWord),
		.inReady(captureReady),
		.outValid(fifoOutValid),
		.outData(fifoOutWord),
		.outReady(fifoOutReady)
	);

	assign selValid = sLinkSel ? linkBValid : fifoOutValid;
	assign selWord = sLinkSel ? linkBWord : fifoOutWord;
	assign fifoOutReady = launch && !sLinkSel;
	assign linkBReady = launch && sLinkSel;

	always_comb
	begin
		d = q;
		raw = '0;
		dec = '0;
		fwd = '0;
		launch = 1'b0;
		d.capValid = 1'b0;
		d.pixClkPrev = sPixClk;
		pixEdge = (sPixClk != q.pixClkPrev) && (sPixClk == q.txEdge);
		if (cfgLoad)
		begin
			d.payload12 = cfgPayload12;
			d.txEdge = cfgTxSampleEdgeSel;
			d.rxEdge = cfgRxLaunchEdgeSel;
			d.sleepSel = cfgSleepStateSelect;
			d.forward = cfgForward;
			d.serLocal = cfgSerLocal;
			d.desLocal = cfgDesLocal;
		end
		// Straps are read once after reset or power-down, never while running
		if (!q.strapDone)
		begin
			d.strapDone = 1'b1;
			d.oscMode = sMode;
			d.addr = vsp_pkg::ADDR_BASE + 7'(sAddr);
		end
		if (pixEdge)
		begin
			raw[11:0] = q.payload12 ? sData : {2'b00, sData[9:0]};
			raw[vsp_pkg::POS_VS] = sVs;
			raw[vsp_pkg::POS_HS] = sHs;
			d.capWord = vsp_pkg::dcEncode(raw, q.disp);
			d.disp = vsp_pkg::dispStep(d.capWord, q.disp);
			d.capValid = 1'b1;
			d.hsPrev = sHs;
			d.vsPrev = sVs;
			// Detects a source that breaks the 10-bit sync spacing; sticky until reset or power-down
			if ((sHs != q.hsPrev) || (sVs != q.vsPrev))
			begin
				if (!q.payload12 && (q.gapCnt < vsp_pkg::SYNC_GAP_PIX - 4'h1))
				begin
					d.syncFault = 1'b1;
				end
				d.gapCnt = 4'h0;
			end
			else if (q.gapCnt != vsp_pkg::SYNC_GAP_PIX)
			begin
				d.gapCnt = q.gapCnt + 4'h1;
			end
		end
		d.lockOut = sLocked;
		if (sLocked)
		begin
			if (q.pclkCnt == vsp_pkg::PCLK_HALF_CYC - 3'h1)
			begin
				d.pclkCnt = 3'h0;
				d.pclk = !q.pclk;
				launch = (!q.pclk) == q.rxEdge;
			end
			else
			begin
				d.pclkCnt = q.pclkCnt + 3'h1;
			end
			// An empty link holds the last pixel, which reads as blanking downstream
			if (launch && selValid)
			begin
				dec = vsp_pkg::dcDecode(selWord);
				d.pixOut = dec[11:0];
				d.vsOut = dec[vsp_pkg::POS_VS];
				d.hsOut = dec[vsp_pkg::POS_HS];
			end
		end
		else
		begin
			d.pclk = 1'b0;
			d.pclkCnt = 3'h0;
			if (!q.sleepSel)
			begin
				d.pixOut = '0;
				d.hsOut = 1'b0;
				d.vsOut = 1'b0;
			end
		end
		if (q.oscCnt == vsp_pkg::OSC_HALF_CYC - 3'h1)
		begin
			d.oscCnt = 3'h0;
			d.oscOut = q.oscMode && !q.oscOut;
		end
		else
		begin
			d.oscCnt = q.oscCnt + 3'h1;
		end
		d.oscInPrev = sOscIn;
		if (q.oscMode && sOscIn && !q.oscInPrev)
		begin
			d.oscSeen = 1'b1;
		end
		// General-purpose pins follow every cycle, blanking or not
		for (int i = 0; i < 4; i++)
		begin
			fwd[i] = q.forward[i] && !(q.oscMode && i >= 2);
			d.gpioOut[i] = q.desLocal[i];
			d.gpioOe_n[i] = fwd[i];
			d.remoteOut[i] = fwd[i] ? sGpio[i] : q.serLocal[i];
			d.remoteOe_n[i] = 1'b0;
		end
		if (q.oscMode)
		begin
			d.remoteOut[2] = q.oscOut;
			d.remoteOut[3] = 1'b0;
			d.remoteOe_n[3] = 1'b1;
		end
		if (!reset_n || !sPd)
		begin
			d = vsp_pkg::TOP_RESET;
			d.pixClkPrev = sPixClk;
		end
	end

	always_ff @(posedge mclk)
	begin
		q <= d;
	end

	assign i2cAddress = q.addr;
	assign oscModeOut = q.oscMode;
	assign syncFault = q.syncFault;
	assign oscClockSeen = q.oscSeen;
	assign lockOut = q.lockOut;
	assign pixelDataOut = q.pixOut;
	assign lineSyncOut = q.hsOut;
	assign frameSyncOut = q.vsOut;
	assign pixClkOut = q.pclk;
	assign remoteOutput = q.remoteOut;
	assign remoteOutputOe_n = q.remoteOe_n;
	assign gpioOut = q.gpioOut;
	assign gpioOe_n = q.gpioOe_n;

	property p_lock_follow;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		!sLocked |=> !lockOut;
	endproperty
	a_lock_follow: assert property (p_lock_follow)
		else $error("lock output high while receiver unlocked");

	property p_sleep_low;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		!sLocked && !q.sleepSel && !cfgLoad |=> pixelDataOut == '0 && !pixClkOut;
	endproperty
	a_sleep_low: assert property (p_sleep_low)
		else $error("outputs not in low sleep state while unlocked");

	property p_powerdown_defaults;
		@(posedge mclk) disable iff (!reset_n)
		!sPd |=> q.forward == 4'h0 && !q.payload12 && !pixClkOut && !q.capValid;
	endproperty
	a_powerdown_defaults: assert property (p_powerdown_defaults)
		else $error("settings kept through power-down");

	property p_mask_10bit;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		pixEdge && !q.payload12 |=> q.capValid &&
			q.capWord[11:10] == {2{q.capWord[vsp_pkg::POS_INV]}};
	endproperty
	a_mask_10bit: assert property (p_mask_10bit)
		else $error("upper data bits carried in 10-bit payload");

	property p_wrong_edge;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		$fell(sPixClk) && q.txEdge && $stable(q.txEdge) |=> !q.capValid;
	endproperty
	a_wrong_edge: assert property (p_wrong_edge)
		else $error("pixel captured on the unselected edge");

	property p_launch_edge;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		launch && !cfgLoad |=> pixClkOut == q.rxEdge;
	endproperty
	a_launch_edge: assert property (p_launch_edge)
		else $error("pixel launched on the unselected output edge");

	property p_osc_pins;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		q.oscMode && $past(q.oscMode) |-> remoteOutputOe_n == 4'h8 && gpioOe_n[3:2] == 2'b00;
	endproperty
	a_osc_pins: assert property (p_osc_pins)
		else $error("oscillator mode pin directions wrong");

	property p_one_link;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		!(linkBReady && fifoOutReady) && (sLinkSel || !linkBReady);
	endproperty
	a_one_link: assert property (p_one_link)
		else $error("both links drained or link B used while A selected");

	property p_forward_zero;
		@(posedge mclk) disable iff (!reset_n || !sPd)
		q.forward[0] && !cfgLoad |=> remoteOutput[0] == $past(sGpio[0]);
	endproperty
	a_forward_zero: assert property (p_forward_zero)
		else $error("remote output 0 does not follow the forwarded pin");

endmodule

// file: tb/vsp_sensor_model.sv
// Image sensor model driving the pixel clock, data and sync pins
`timescale 1ns/10ps
module vsp_sensor_model (
	// Pixel pins
	output logic pixClk,
	output logic [11:0] pixData,
	output logic lineSync,
	output logic frameSync
);
	initial
	begin
		pixClk = 1'b0;
		pixData = 12'h000;
		lineSync = 1'b0;
		frameSync = 1'b0;
	end

	// Data moves on the edge opposite the sampling one, so either choice sees it settled
	task automatic pixel(input logic rise, input logic [11:0] d, input logic hs, input logic vs);
		if (!rise)
			pixClk = 1'b1;
		pixData = d;
		lineSync = hs;
		frameSync = vs;
		#80;
		pixClk = ~pixClk;
		#80;
		if (rise)
			pixClk = 1'b0;
	endtask

	// Clock stands low between frames; pulled-down pins fall once hold is over
	task automatic idle();
		pixClk = 1'b0;
		pixData = 12'h000;
		lineSync = 1'b0;
		frameSync = 1'b0;
	endtask
endmodule

// file: tb/vsp_pin_logic_test.sv
// Self-checking bench for the video serdes pin logic
`timescale 1ns/10ps
module vsp_pin_logic_test;
	logic mclk = 1'b0, reset_n = 1'b0, powerDown_n = 1'b1, modeStrap = 1'b0;
	logic [2:0] addressStrap = 3'h0;
	logic pixClkIn, lineSyncIn, frameSyncIn, captureReady, cfgLoad = 1'b0;
	logic [11:0] pixDataIn, pixelDataOut;
	logic cfgPayload12 = 1'b0, cfgTxSampleEdgeSel = 1'b0, cfgRxLaunchEdgeSel = 1'b0;
	logic cfgSleepStateSelect = 1'b0, linkBValid = 1'b0, linkSel = 1'b0, rxPllLocked = 1'b1;
	logic [3:0] cfgForward = 4'h0, cfgSerLocal = 4'h0, cfgDesLocal = 4'h0, gpioIn = 4'h0;
	logic [6:0] i2cAddress;
	logic oscModeOut, syncFault, oscClockSeen, linkBReady, lockOut, lineSyncOut, frameSyncOut;
	logic pixClkOut, oscClockIn = 1'b0;
	logic [14:0] linkBWord = 15'h0000;
	logic [3:0] remoteOutput, remoteOutputOe_n, gpioOut, gpioOe_n;
	logic [31:0] seed = 32'h7e824770;
	logic p12 = 1'b0, txRise = 1'b0, rxEdge = 1'b0, monEn = 1'b1;
	logic [13:0] q[$];
	logic [13:0] last = 14'h0000;
	wire logic [13:0] cur = {lineSyncOut, frameSyncOut, pixelDataOut};
	int fail_count = 0, check_count = 0;

	vsp_pin_logic DUT (.mclk(mclk), .reset_n(reset_n), .powerDown_n(powerDown_n),
		.modeStrap(modeStrap), .addressStrap(addressStrap), .pixClkIn(pixClkIn),
		.pixDataIn(pixDataIn), .lineSyncIn(lineSyncIn), .frameSyncIn(frameSyncIn),
		.captureReady(captureReady), .cfgLoad(cfgLoad), .cfgPayload12(cfgPayload12),
		.cfgTxSampleEdgeSel(cfgTxSampleEdgeSel), .cfgRxLaunchEdgeSel(cfgRxLaunchEdgeSel),
		.cfgSleepStateSelect(cfgSleepStateSelect), .cfgForward(cfgForward),
		.cfgSerLocal(cfgSerLocal), .cfgDesLocal(cfgDesLocal), .i2cAddress(i2cAddress),
		.oscModeOut(oscModeOut), .syncFault(syncFault), .oscClockSeen(oscClockSeen),
		.linkBWord(linkBWord), .linkBValid(linkBValid), .linkBReady(linkBReady),
		.rxPllLocked(rxPllLocked), .linkSel(linkSel), .lockOut(lockOut),
		.pixelDataOut(pixelDataOut), .lineSyncOut(lineSyncOut), .frameSyncOut(frameSyncOut),
		.pixClkOut(pixClkOut), .remoteOutput(remoteOutput), .remoteOutputOe_n(remoteOutputOe_n),
		.oscClockIn(oscClockIn), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n));

	vsp_sensor_model sensor (.pixClk(pixClkIn), .pixData(pixDataIn), .lineSync(lineSyncIn),
		.frameSync(frameSyncIn));

	always #10 mclk = ~mclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cfg(input logic p, input logic tx, input logic rx, input logic sl,
		input logic [3:0] fw, input logic [3:0] sv, input logic [3:0] dv);
		@(posedge mclk);
		cfgPayload12 <= p;
		cfgTxSampleEdgeSel <= tx;
		cfgRxLaunchEdgeSel <= rx;
		cfgSleepStateSelect <= sl;
		cfgForward <= fw;
		cfgSerLocal <= sv;
		cfgDesLocal <= dv;
		cfgLoad <= 1'b1;
		@(posedge mclk);
		cfgLoad <= 1'b0;
		p12 = p;
		txRise = tx;
		rxEdge = rx;
		repeat (4) @(posedge mclk);
	endtask

	// Consecutive pixels always differ in their low bits, so the watcher sees each one
	task automatic frame(input int n, input logic tgl);
		logic [11:0] d;
		logic hs, vs;
		#7;
		for (int i = 0; i < n; i++)
		begin
			seed = lfsr(seed);
			d = {seed[11:4], 4'(i)};
			hs = tgl & i[0];
			vs = tgl & i[1];
			q.push_back({hs, vs, p12 ? d : {2'b00, d[9:0]}});
			sensor.pixel(txRise, d, hs, vs);
		end
		sensor.idle();
		@(posedge mclk);
	endtask

	task automatic link_b(input logic [13:0] raw, input logic inv);
		@(posedge mclk);
		q.push_back(raw);
		linkBWord <= inv ? {1'b1, ~raw} : {1'b0, raw};
		linkBValid <= 1'b1;
		for (int n = 0; n < 40; n++)
		begin
			#1;
			if (linkBReady === 1'b1)
				break;
			@(posedge mclk);
		end
		@(posedge mclk);
		linkBValid <= 1'b0;
	endtask

	task automatic drain();
		for (int n = 0; n < 600 && q.size() > 0; n++)
			@(posedge mclk);
		check(32'(q.size()), 32'h0);
	endtask

	// Each new output pixel is compared with the oldest expected one
	always @(posedge mclk)
	begin
		if (monEn && lockOut === 1'b1 && cur !== last)
		begin
			if (q.size() == 0)
				check(32'(cur), 32'hffffffff);
			else
				check(32'(cur), 32'(q.pop_front()));
			check(32'(pixClkOut), 32'(rxEdge));
		end
		last <= cur;
	end

	initial
	begin
		#400000;
		fail_count++;
		end_sim();
	end

	initial
	begin
		logic a;
		repeat (20) @(posedge mclk);
		seed = lfsr(seed);
		addressStrap <= seed[2:0];
		gpioIn <= seed[7:4];
		reset_n <= 1'b1;
		repeat (20) @(posedge mclk);
		check(32'(i2cAddress), 32'(vsp_pkg::ADDR_BASE + 7'(addressStrap)));
		check(32'(oscModeOut), 32'h0);
		cfg(1'b0, 1'b1, 1'b1, 1'b1, 4'h3, 4'hc, 4'ha);
		repeat (8) @(posedge mclk);
		check(32'(remoteOutput), 32'({2'b11, gpioIn[1:0]}));
		check(32'({gpioOe_n, gpioOut}), 32'h3a);
		frame(8, 1'b0);
		drain();
		cfg(1'b1, 1'b0, 1'b0, 1'b1, 4'h3, 4'hc, 4'ha);
		frame(8, 1'b1);
		drain();
		check(32'(syncFault), 32'h0);
		linkSel <= 1'b1;
		link_b(14'h25a5, 1'b0);
		link_b(14'h1a5a, 1'b1);
		drain();
		linkSel <= 1'b0;
		rxPllLocked <= 1'b0;
		repeat (10) @(posedge mclk);
		check(32'({lockOut, pixClkOut}), 32'h0);
		frame(32, 1'b0);
		repeat (8) @(posedge mclk);
		check(32'(captureReady), 32'h0);
		rxPllLocked <= 1'b1;
		drain();
		check(32'(captureReady), 32'h1);
		cfg(1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 4'hc, 4'ha);
		frame(12, 1'b1);
		drain();
		check(32'(syncFault), 32'h1);
		monEn <= 1'b0;
		rxPllLocked <= 1'b0;
		repeat (10) @(posedge mclk);
		check(32'({lockOut, pixClkOut, pixelDataOut}), 32'h0);
		powerDown_n <= 1'b0;
		modeStrap <= 1'b1;
		gpioIn <= 4'hf;
		repeat (10) @(posedge mclk);
		check(32'({remoteOutput, syncFault}), 32'h0);
		powerDown_n <= 1'b1;
		repeat (10) @(posedge mclk);
		check(32'({oscModeOut, gpioOe_n}), 32'h10);
		cfg(1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 4'h0, 4'h0);
		repeat (4) @(posedge mclk);
		check(32'({remoteOutputOe_n[3], gpioOe_n}), 32'h13);
		repeat (4)
		begin
			repeat (4) @(posedge mclk);
			oscClockIn <= ~oscClockIn;
		end
		repeat (8) @(posedge mclk);
		check(32'(oscClockSeen), 32'h1);
		a = remoteOutput[2];
		repeat (vsp_pkg::OSC_HALF_CYC) @(posedge mclk);
		check(32'(remoteOutput[2]), 32'(!a));
		end_sim();
	end
endmodule
